// ### include/bsms_pkg.sv
// Shared constants and types of the backplane slave memory sequencer.
package bsms_pkg;

    // Clock and arbitration timing.
    localparam int unsigned CLK_FREQ_MHZ    = 200;
    localparam int unsigned ARB_SETUP_NS    = 20;
    localparam int unsigned ARB_HOLD_NS     = 0;
    localparam int unsigned ALE_HOLD_RAW    = (ARB_SETUP_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned ALE_HOLD_CYCLES = (ALE_HOLD_RAW < 1) ? 1 : ALE_HOLD_RAW;
    localparam logic [3:0]  ALE_HOLD_CNT    = 4'(ALE_HOLD_CYCLES - 1);

    // Register byte offsets inside the 4 KiB slave window.
    localparam logic [11:0] REG_CTRL_OFS    = 12'h000;
    localparam logic [11:0] REG_STATUS_OFS  = 12'h004;
    localparam logic [11:0] REG_COUNT_OFS   = 12'h008;
    localparam logic [11:0] REG_REFWAIT_OFS = 12'h00c;

    // Control register fields and reset value.
    localparam int unsigned CTRL_FS0_BIT    = 0;
    localparam int unsigned CTRL_FS1_BIT    = 1;
    localparam int unsigned CTRL_EN_BIT     = 2;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0005;

    // Status register field positions.
    localparam int unsigned STAT_IN_LSB     = 0;
    localparam int unsigned STAT_STATE_LSB  = 12;
    localparam int unsigned STAT_TYPE_LSB   = 16;

    // Positions of the pin inputs in the synchronised vector.
    localparam int unsigned IN_SREQ_N       = 0;
    localparam int unsigned IN_QUAL         = 1;
    localparam int unsigned IN_BRST_N       = 2;
    localparam int unsigned IN_DRAM_SEL_N   = 3;
    localparam int unsigned IN_ROM_SEL_N    = 4;
    localparam int unsigned IN_RCLR         = 5;
    localparam int unsigned IN_CAS_N        = 6;
    localparam int unsigned IN_LANE_LSB     = 7;
    localparam int unsigned IN_WIDTH        = 11;
    localparam logic [10:0] IN_RESET        = 11'h7fd;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_DRAM_WAIT = 3'b001,
        ST_ACK       = 3'b010,
        ST_DONE      = 3'b011
    } bsms_state_t;

    typedef enum logic [1:0] {
        ACC_DRAM_RD  = 2'b00,
        ACC_DRAM_WR  = 2'b01,
        ACC_ROM_RD   = 2'b10,
        ACC_INVALID  = 2'b11
    } bsms_acc_t;

endpackage : bsms_pkg

// ### verilog/bsms_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module bsms_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             clk_en_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    if (WIDTH < 1) $error("bsms_sync: WIDTH must be at least 1.");

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else if (clk_en_i)
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : bsms_sync

// ### verilog/bsms_sequencer.sv
// Backplane slave memory sequencer with its AHB-Lite register slave.
//
// Overview of operation
// - Sequencer and DRAM controller share one clock from the bus controller.
// - Never drop the access request within 20 ns before arbitration edge.
// - Sequencer drives both refresh selects, in reset and in operation.
// - Per-byte column strobes combine column strobe with four byte lanes.
// - Latched bus reset low holds the sequencer in its idle state.
// - After reset, idle waits for DRAM read, write, ROM read or invalid.
// - All control inputs are sampled; outputs follow the decoded access type.
// - Request, qualifier and DRAM select low, ROM high: DRAM read, request low.
// - Acknowledge a DRAM access only while refresh-clear is high.
// - DRAM write as read but write strobe low; reads keep it high.
// - Request, ROM select, qualifier low with DRAM select high: ROM read.
// - Both selects high, or ROM with qualifier high, is an invalid access.
// - Invalid access ends with error status on the bus.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module bsms_sequencer (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // AHB-Lite slave.
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Bus interface controller side.
    input  wire logic        slave_request_n_i,
    input  wire logic        latched_transfer_qualifier_i,
    input  wire logic        latched_bus_reset_n_i,
    input  wire logic [3:0]  byte_lane_n_i,
    output logic             local_acknowledge_n_o,
    output logic             local_status_mode0_n_o,
    // Address decoder side.
    input  wire logic        dram_select_n_i,
    input  wire logic        rom_select_n_i,
    // DRAM controller side.
    input  wire logic        refresh_clear_i,
    input  wire logic        column_strobe_n_i,
    output logic             access_request_n_o,
    output logic             dram_write_n_o,
    output logic             refresh_select_0_o,
    output logic             refresh_select_1_o,
    output logic [3:0]       byte_column_strobe_n_o,
    // ROM side.
    output logic             rom_output_enable_n_o
);

    typedef struct packed {
        bsms_pkg::bsms_state_t state;
        bsms_pkg::bsms_acc_t   acc;
        logic [3:0]            hold_cnt;
        logic                  ale_n;
        logic                  we_n;
        logic                  local_acknowledge_n_n;
        logic                  tm0_n;
        logic                  rom_oe_n;
        logic [3:0]            bcas_n;
        logic                  fs0;
        logic                  fs1;
        logic                  seq_en;
        logic [15:0]           acc_cnt;
        logic [15:0]           err_cnt;
        logic [15:0]           rwait_cnt;
        logic                  wr_pend;
        logic [11:0]           wr_addr;
        logic [31:0]           rdata;
    } bsms_regs_t;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic [15:0] CNT_MAX      = 16'hffff;

    bsms_regs_t q;
    bsms_regs_t d;
    logic [bsms_pkg::IN_WIDTH-1:0] in_s;
    logic [bsms_pkg::IN_WIDTH-1:0] in_raw;

    if (bsms_pkg::ALE_HOLD_CYCLES > 16) $error("bsms_sequencer: request hold count exceeds counter.");

    // Every pin input is sampled through two flip-flops before use.
    assign in_raw = {byte_lane_n_i, column_strobe_n_i, refresh_clear_i, rom_select_n_i,
                     dram_select_n_i, latched_bus_reset_n_i, latched_transfer_qualifier_i,
                     slave_request_n_i};

    bsms_sync #(
        .WIDTH     (bsms_pkg::IN_WIDTH),
        .RESET_VAL (bsms_pkg::IN_RESET)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   (in_raw),
        .sync_o    (in_s)
    );

    // Classifies a request from the qualifier and the two decode selects.
    function automatic bsms_pkg::bsms_acc_t classify(input logic qual, input logic dsel_n, input logic rsel_n);
        bsms_pkg::bsms_acc_t r;
        r = bsms_pkg::ACC_INVALID;
        if (!dsel_n && rsel_n)
        begin
            r = qual ? bsms_pkg::ACC_DRAM_WR : bsms_pkg::ACC_DRAM_RD;
        end
        else if (!rsel_n && dsel_n && !qual)
        begin
            r = bsms_pkg::ACC_ROM_RD;
        end
        // Both selects high, a ROM write, or a decoder fault with both low.
        return r;
    endfunction : classify

    // Saturating increment, so a counter never wraps back to a small value.
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == CNT_MAX) ? v : 16'(v + 16'h0001);
    endfunction : sat_inc

    always_comb
    begin
        logic                ahb_go;
        logic                clr_cnt;
        logic                ev_acc;
        logic                ev_err;
        logic                ev_wait;
        logic [11:0]         ra;
        bsms_pkg::bsms_acc_t kind;

        d       = q;
        ahb_go  = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
        clr_cnt = 1'b0;
        ev_acc  = 1'b0;
        ev_err  = 1'b0;
        ev_wait = 1'b0;
        ra      = haddr_i[11:0];
        kind    = classify(in_s[bsms_pkg::IN_QUAL], in_s[bsms_pkg::IN_DRAM_SEL_N], in_s[bsms_pkg::IN_ROM_SEL_N]);

        // Register writes land in the data phase.
        d.wr_pend = 1'b0;
        if (q.wr_pend)
        begin
            if (q.wr_addr == bsms_pkg::REG_CTRL_OFS)
            begin
                d.fs0    = hwdata_i[bsms_pkg::CTRL_FS0_BIT];
                d.fs1    = hwdata_i[bsms_pkg::CTRL_FS1_BIT];
                d.seq_en = hwdata_i[bsms_pkg::CTRL_EN_BIT];
            end
            else if (q.wr_addr == bsms_pkg::REG_COUNT_OFS)
            begin
                clr_cnt = 1'b1;
            end
            else if (q.wr_addr == bsms_pkg::REG_REFWAIT_OFS)
            begin
                d.rwait_cnt = 16'h0000;
            end
        end

        // Read data is prepared in the address phase and stands in the data phase.
        if (ahb_go && hwrite_i && (hsize_i == HSIZE_WORD))
        begin
            d.wr_pend = 1'b1;
            d.wr_addr = ra;
        end
        if (ahb_go && !hwrite_i)
        begin
            d.rdata = 32'h0000_0000;
            if (ra == bsms_pkg::REG_CTRL_OFS)
            begin
                d.rdata[bsms_pkg::CTRL_FS0_BIT] = q.fs0;
                d.rdata[bsms_pkg::CTRL_FS1_BIT] = q.fs1;
                d.rdata[bsms_pkg::CTRL_EN_BIT]  = q.seq_en;
            end
            else if (ra == bsms_pkg::REG_STATUS_OFS)
            begin
                d.rdata[bsms_pkg::STAT_IN_LSB +: bsms_pkg::IN_WIDTH] = in_s;
                d.rdata[bsms_pkg::STAT_STATE_LSB +: 3]               = q.state;
                d.rdata[bsms_pkg::STAT_TYPE_LSB +: 2]                = q.acc;
            end
            else if (ra == bsms_pkg::REG_COUNT_OFS)
            begin
                d.rdata = {q.err_cnt, q.acc_cnt};
            end
            else if (ra == bsms_pkg::REG_REFWAIT_OFS)
            begin
                d.rdata = {16'h0000, q.rwait_cnt};
            end
        end

        // Per-byte column strobes; a lane strobes only when both are low.
        for (int i = 0; i < 4; i++)
        begin
            d.bcas_n[i] = in_s[bsms_pkg::IN_CAS_N] | in_s[bsms_pkg::IN_LANE_LSB + i];
        end

        case (q.state)
            bsms_pkg::ST_IDLE:
            begin
                if (!in_s[bsms_pkg::IN_SREQ_N] && q.seq_en)
                begin
                    d.acc = kind;
                    case (kind)
                        bsms_pkg::ACC_DRAM_RD, bsms_pkg::ACC_DRAM_WR:
                        begin
                            // The request falls right after a clock edge, never near the next one.
                            d.ale_n    = 1'b0;
                            d.we_n     = (kind == bsms_pkg::ACC_DRAM_RD);
                            d.hold_cnt = bsms_pkg::ALE_HOLD_CNT;
                            d.state    = bsms_pkg::ST_DRAM_WAIT;
                        end
                        bsms_pkg::ACC_ROM_RD:
                        begin
                            d.rom_oe_n = 1'b0;
                            d.local_acknowledge_n_n   = 1'b0;
                            ev_acc     = 1'b1;
                            d.state    = bsms_pkg::ST_ACK;
                        end
                        default:
                        begin
                            d.local_acknowledge_n_n = 1'b0;
                            d.tm0_n  = 1'b0;
                            ev_err   = 1'b1;
                            d.state  = bsms_pkg::ST_ACK;
                        end
                    endcase
                end
            end
            bsms_pkg::ST_DRAM_WAIT:
            begin
                // The request stays low at least the arbitration setup time.
                if (q.hold_cnt != 4'h0)
                begin
                    d.hold_cnt = 4'(q.hold_cnt - 4'h1);
                end
                else if (in_s[bsms_pkg::IN_RCLR])
                begin
                    d.local_acknowledge_n_n = 1'b0;
                    ev_acc   = 1'b1;
                    d.state  = bsms_pkg::ST_ACK;
                end
                else
                begin
                    ev_wait = 1'b1;
                end
            end
            bsms_pkg::ST_ACK:
            begin
                d.ale_n    = 1'b1;
                d.we_n     = 1'b1;
                d.local_acknowledge_n_n   = 1'b1;
                d.tm0_n    = 1'b1;
                d.rom_oe_n = 1'b1;
                d.state    = bsms_pkg::ST_DONE;
            end
            bsms_pkg::ST_DONE:
            begin
                if (in_s[bsms_pkg::IN_SREQ_N])
                begin
                    d.state = bsms_pkg::ST_IDLE;
                end
            end
            default:
            begin
                d.state = bsms_pkg::ST_IDLE;
            end
        endcase

        // Latched bus reset overrides the sequence but not the register slave.
        if (!in_s[bsms_pkg::IN_BRST_N])
        begin
            d.state    = bsms_pkg::ST_IDLE;
            d.ale_n    = 1'b1;
            d.we_n     = 1'b1;
            d.local_acknowledge_n_n   = 1'b1;
            d.tm0_n    = 1'b1;
            d.rom_oe_n = 1'b1;
            d.hold_cnt = 4'h0;
            ev_acc     = 1'b0;
            ev_err     = 1'b0;
            ev_wait    = 1'b0;
        end

        // A clear and an event in one cycle leave the event counted.
        if (clr_cnt)
        begin
            d.acc_cnt = 16'h0000;
            d.err_cnt = 16'h0000;
        end
        if (ev_acc)
        begin
            d.acc_cnt = sat_inc(d.acc_cnt);
        end
        if (ev_err)
        begin
            d.err_cnt = sat_inc(d.err_cnt);
        end
        if (ev_wait)
        begin
            d.rwait_cnt = sat_inc(d.rwait_cnt);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            q           <= '0;
            q.state     <= bsms_pkg::ST_IDLE;
            q.acc       <= bsms_pkg::ACC_DRAM_RD;
            q.ale_n     <= 1'b1;
            q.we_n      <= 1'b1;
            q.local_acknowledge_n_n    <= 1'b1;
            q.tm0_n     <= 1'b1;
            q.rom_oe_n  <= 1'b1;
            q.bcas_n    <= 4'hf;
            q.fs0       <= bsms_pkg::CTRL_RESET[bsms_pkg::CTRL_FS0_BIT];
            q.fs1       <= bsms_pkg::CTRL_RESET[bsms_pkg::CTRL_FS1_BIT];
            q.seq_en    <= bsms_pkg::CTRL_RESET[bsms_pkg::CTRL_EN_BIT];
        end
        else if (clk_en_i)
        begin
            q <= d;
        end
    end

    // Zero-wait slave; every transfer completes with OKAY.
    assign hrdata_o               = q.rdata;
    assign hreadyout_o            = 1'b1;
    assign hresp_o                = 1'b0;
    assign local_acknowledge_n_o  = q.local_acknowledge_n_n;
    assign local_status_mode0_n_o = q.tm0_n;
    assign access_request_n_o     = q.ale_n;
    assign dram_write_n_o         = q.we_n;
    assign refresh_select_0_o     = q.fs0;
    assign refresh_select_1_o     = q.fs1;
    assign byte_column_strobe_n_o = q.bcas_n;
    assign rom_output_enable_n_o  = q.rom_oe_n;

endmodule : bsms_sequencer

// ### bench/bsms_dram_model.sv
// Behavioural model of the DRAM controller facing the sequencer.
`timescale 1ns/1ps
module bsms_dram_model (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic access_request_n_i,
    input  wire logic collide_i,
    output logic      refresh_clear_o,
    output logic      column_strobe_n_o
);
    logic       ale_q;
    logic       busy_q;
    logic [2:0] cnt_q;
    assign refresh_clear_o = ~busy_q;
    // Arbitration is sampled on the rising edge of the shared clock only.
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ale_q <= 1'b1;
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
            column_strobe_n_o <= 1'b1;
        end
        else
        begin
            ale_q <= access_request_n_i;
            if (ale_q && !access_request_n_i && collide_i)
            begin
                busy_q <= 1'b1;
                cnt_q <= 3'h0;
            end
            else if (busy_q)
            begin
                cnt_q <= cnt_q + 3'h1;
                busy_q <= (cnt_q != 3'h7);
            end
            column_strobe_n_o <= access_request_n_i | busy_q;
        end
    end
endmodule : bsms_dram_model

// ### bench/bsms_sequencer_properties.sv
// Concurrent checks on the sequencer's pins.
`timescale 1ns/1ps
module bsms_sequencer_properties (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       slave_request_n_i,
    input  wire logic       latched_bus_reset_n_i,
    input  wire logic [3:0] byte_lane_n_i,
    input  wire logic       dram_select_n_i,
    input  wire logic       rom_select_n_i,
    input  wire logic       refresh_clear_i,
    input  wire logic       column_strobe_n_i,
    input  wire logic       local_acknowledge_n_o,
    input  wire logic       local_status_mode0_n_o,
    input  wire logic       access_request_n_o,
    input  wire logic       dram_write_n_o,
    input  wire logic [3:0] byte_column_strobe_n_o,
    input  wire logic       rom_output_enable_n_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Pins pass two synchroniser stages and one output flop, hence the depth of three.
    property p_ale_hold; $fell(access_request_n_o) |-> (!access_request_n_o)[*4]; endproperty
    a_ale_hold: assert property (p_ale_hold) else $error("access request dropped too early");
    property p_dram_start;
        $fell(access_request_n_o) |-> !$past(slave_request_n_i, 3) && !$past(dram_select_n_i, 3)
            && $past(rom_select_n_i, 3);
    endproperty
    a_dram_start: assert property (p_dram_start) else $error("access request without DRAM decode");
    property p_rclr_ack; !local_acknowledge_n_o && !access_request_n_o |-> $past(refresh_clear_i, 3); endproperty
    a_rclr_ack: assert property (p_rclr_ack) else $error("DRAM acknowledge during refresh");
    property p_write_dram; !dram_write_n_o |-> !access_request_n_o; endproperty
    a_write_dram: assert property (p_write_dram) else $error("write strobe outside DRAM access");
    property p_write_steady; !access_request_n_o && !$fell(access_request_n_o) |-> $stable(dram_write_n_o); endproperty
    a_write_steady: assert property (p_write_steady) else $error("write strobe moved in access");
    property p_ack_release;
        !local_acknowledge_n_o |=> local_acknowledge_n_o && access_request_n_o && dram_write_n_o;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("strobes not released after ack");
    property p_err_ack;
        !local_status_mode0_n_o |-> !local_acknowledge_n_o && access_request_n_o && rom_output_enable_n_o;
    endproperty
    a_err_ack: assert property (p_err_ack) else $error("error status without lone ack");
    property p_rom_ack; !rom_output_enable_n_o |-> !local_acknowledge_n_o && access_request_n_o; endproperty
    a_rom_ack: assert property (p_rom_ack) else $error("ROM enable without ack");
    property p_lanes;
        byte_column_strobe_n_o == ($past(byte_lane_n_i, 3) | {4{$past(column_strobe_n_i, 3)}});
    endproperty
    a_lanes: assert property (p_lanes) else $error("byte column strobes wrong");
    property p_bus_reset;
        (!latched_bus_reset_n_i)[*4] |-> access_request_n_o && local_acknowledge_n_o && dram_write_n_o;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("sequencer active in bus reset");
endmodule : bsms_sequencer_properties
bind bsms_sequencer bsms_sequencer_properties i_props (.ref_clk_i, .sys_rst_i, .slave_request_n_i,
    .latched_bus_reset_n_i, .byte_lane_n_i, .dram_select_n_i, .rom_select_n_i, .refresh_clear_i,
    .column_strobe_n_i, .local_acknowledge_n_o, .local_status_mode0_n_o, .access_request_n_o, .dram_write_n_o,
    .byte_column_strobe_n_o, .rom_output_enable_n_o);

// ### bench/bsms_sequencer_tb_top.sv
// Self-checking testbench of the backplane slave memory sequencer.
`timescale 1ns/1ps
module bsms_sequencer_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        clk_en_i = 1'b1;
    logic        hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic        hwrite_i = 1'b0;
    logic [2:0]  hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic        hready_i;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic        slave_request_n_i = 1'b1;
    logic        latched_transfer_qualifier_i = 1'b0;
    logic        latched_bus_reset_n_i = 1'b1;
    logic [3:0]  byte_lane_n_i = 4'hf;
    logic        dram_select_n_i = 1'b1;
    logic        rom_select_n_i = 1'b1;
    logic        refresh_clear_i;
    logic        column_strobe_n_i;
    logic        local_acknowledge_n_o;
    logic        local_status_mode0_n_o;
    logic        access_request_n_o;
    logic        dram_write_n_o;
    logic        refresh_select_0_o;
    logic        refresh_select_1_o;
    logic [3:0]  byte_column_strobe_n_o;
    logic        rom_output_enable_n_o;
    logic        collide = 1'b0;
    logic        mem_rst;
    logic [31:0] rd;
    logic [6:0]  res;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    assign hready_i = hreadyout_o;
    // The DRAM controller is reset by the bus reset as well.
    assign mem_rst = sys_rst_i | ~latched_bus_reset_n_i;
    always #2.5 ref_clk_i = ~ref_clk_i;
    bsms_sequencer i_dut (.ref_clk_i, .sys_rst_i, .clk_en_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .slave_request_n_i, .latched_transfer_qualifier_i,
        .latched_bus_reset_n_i, .byte_lane_n_i, .local_acknowledge_n_o, .local_status_mode0_n_o, .dram_select_n_i,
        .rom_select_n_i, .refresh_clear_i, .column_strobe_n_i, .access_request_n_o, .dram_write_n_o,
        .refresh_select_0_o, .refresh_select_1_o, .byte_column_strobe_n_o, .rom_output_enable_n_o);
    bsms_dram_model i_mem (.ref_clk_i, .rst_i(mem_rst), .access_request_n_i(access_request_n_o),
        .collide_i(collide), .refresh_clear_o(refresh_clear_i), .column_strobe_n_o(column_strobe_n_i));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0, ofs};
        hwrite_i <= wr;
        htrans_i <= 2'h2;
        do @(posedge ref_clk_i); while (hready_i !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge ref_clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
    endtask : ahb
    // Result packs write strobe, error status, ROM enable and byte strobes seen in the ack cycle.
    task automatic access(input logic q, input logic ds, input logic rs, output logic [6:0] r);
        r = 'x;
        slave_request_n_i <= 1'b0;
        latched_transfer_qualifier_i <= q;
        dram_select_n_i <= ds;
        rom_select_n_i <= rs;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge ref_clk_i);
            if (local_acknowledge_n_o === 1'b0)
            begin
                r = {dram_write_n_o, local_status_mode0_n_o, rom_output_enable_n_o, byte_column_strobe_n_o};
                break;
            end
        end
        @(posedge ref_clk_i);
        slave_request_n_i <= 1'b1;
        dram_select_n_i <= 1'b1;
        rom_select_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask : access
    task automatic t_reset();
        chk("idle pins", 32'({hreadyout_o, hresp_o, refresh_select_1_o, refresh_select_0_o, local_acknowledge_n_o,
            local_status_mode0_n_o, access_request_n_o, dram_write_n_o, rom_output_enable_n_o,
            byte_column_strobe_n_o}), 32'h13ff);
        ahb(1'b0, bsms_pkg::REG_CTRL_OFS, 32'h0);
        chk("control reset", rd, bsms_pkg::CTRL_RESET);
        ahb(1'b1, bsms_pkg::REG_COUNT_OFS, 32'h0);
        ahb(1'b0, 12'h010, 32'h0);
        chk("unmapped read", rd, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_dram();
        byte_lane_n_i <= 4'h3;
        access(1'b0, 1'b0, 1'b1, res);
        chk("dram read", 32'(res), 32'h73);
        collide <= 1'b1;
        byte_lane_n_i <= 4'h0;
        access(1'b1, 1'b0, 1'b1, res);
        collide <= 1'b0;
        chk("dram write", 32'(res[6:4]), 32'h3);
        ahb(1'b0, bsms_pkg::REG_REFWAIT_OFS, 32'h0);
        chk("refresh stall", 32'(rd[15:0] != 16'h0), 32'h1);
        $display("test dram done");
    endtask : t_dram
    task automatic t_rom_invalid();
        access(1'b0, 1'b1, 1'b0, res);
        chk("rom read", 32'(res[6:4]), 32'h6);
        access(1'b0, 1'b1, 1'b1, res);
        chk("no decode", 32'(res[6:4]), 32'h5);
        access(1'b1, 1'b1, 1'b0, res);
        chk("rom write", 32'(res[6:4]), 32'h5);
        ahb(1'b0, bsms_pkg::REG_COUNT_OFS, 32'h0);
        chk("access counts", rd, 32'h0002_0003);
        ahb(1'b0, bsms_pkg::REG_STATUS_OFS, 32'h0);
        chk("last type", 32'(rd[17:16]), 32'h3);
        $display("test rom and invalid done");
    endtask : t_rom_invalid
    task automatic t_select();
        ahb(1'b1, bsms_pkg::REG_CTRL_OFS, 32'h6);
        repeat (2) @(posedge ref_clk_i);
        chk("selects swapped", 32'({refresh_select_1_o, refresh_select_0_o}), 32'h2);
        clk_en_i <= 1'b0;
        ahb(1'b1, bsms_pkg::REG_CTRL_OFS, 32'h1);
        chk("frozen", 32'({refresh_select_1_o, refresh_select_0_o}), 32'h2);
        clk_en_i <= 1'b1;
        ahb(1'b1, bsms_pkg::REG_CTRL_OFS, 32'h5);
        repeat (2) @(posedge ref_clk_i);
        chk("selects restored", 32'({refresh_select_1_o, refresh_select_0_o}), 32'h1);
        $display("test selects done");
    endtask : t_select
    task automatic t_bus_reset();
        collide <= 1'b1;
        slave_request_n_i <= 1'b0;
        latched_transfer_qualifier_i <= 1'b0;
        dram_select_n_i <= 1'b0;
        for (int i = 0; i < 40 && access_request_n_o !== 1'b0; i++)
            @(negedge ref_clk_i);
        chk("request started", 32'(access_request_n_o), 32'h0);
        repeat (4) @(posedge ref_clk_i);
        latched_bus_reset_n_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        chk("aborted pins", 32'({access_request_n_o, local_acknowledge_n_o, dram_write_n_o}), 32'h7);
        slave_request_n_i <= 1'b1;
        dram_select_n_i <= 1'b1;
        collide <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        latched_bus_reset_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        access(1'b0, 1'b0, 1'b1, res);
        chk("read after bus reset", 32'(res[6:4]), 32'h7);
        $display("test bus reset done");
    endtask : t_bus_reset
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_dram();
        t_rom_invalid();
        t_select();
        t_bus_reset();
        finish_test();
    end
endmodule : bsms_sequencer_tb_top
